// ---- common/nhf_consts.vh ----
// nhf_consts.vh : offsets, field positions, reset values and timing counts
// assumes: included by bare name from the rtl files of the nhf block
`ifndef NHF_CONSTS_VH
`define NHF_CONSTS_VH

// =====================================================================
// clock and timing
// =====================================================================
`define NHF_CLK_HZ          50000000
`define NHF_SELFTEST_MS     25
`define NHF_BLACKOUT_MS     1
// least time rounds up; both far above 4096 so the top makes parameters
`define NHF_SELFTEST_CYC    ((`NHF_CLK_HZ / 1000) * `NHF_SELFTEST_MS)
`define NHF_BLACKOUT_CYC    ((`NHF_CLK_HZ / 1000) * `NHF_BLACKOUT_MS)

// =====================================================================
// filter table layout
// =====================================================================
`define NHF_TABLE_BITS      512
`define NHF_HASH_W          9
`define NHF_LWORD_W         32
`define NHF_LWORDS          16
`define NHF_ADDR_W          48
`define NHF_CRC_INIT        32'hffffffff
`define NHF_CRC_POLY        32'h04c11db7

// =====================================================================
// irq_status_reg field positions
// =====================================================================
`define NHF_ST_RX_DONE      0
`define NHF_ST_TX_DONE      1
`define NHF_ST_RX_UNAVAIL   2
`define NHF_ST_INIT_DONE    3
`define NHF_ST_FAIL         4
`define NHF_ST_RST_DONE     5
`define NHF_ST_CODE_LO      8
`define NHF_ST_W            12
`define NHF_ST_IRQ_MASK     12'h007

// =====================================================================
// reset values of fields that do not reset to zero
// =====================================================================
`define NHF_BURST_RST       4'h1
`define NHF_WDOG_RST        16'h04e2

`endif

// ---- rtl/nhf_crc_hash.v ----
// nhf_crc_hash.v : serial-equivalent address CRC, folded into one cycle
// assumes: destination address arrives as one 48-bit word, byte 0 low
`timescale 1ns/1ns
`default_nettype none
`include "nhf_consts.vh"

module nhf_crc_hash (
    // address in
    input  wire [47:0] dest_addr,
    // hash index out
    output wire [8:0]  hash_index
);

    // =================================================================
    // crc walk
    // =================================================================
    // one crc step per address bit, lsb of each half first
    function [31:0] nhf_step;
        input [31:0] crc;
        input        din;
        reg          fb;
        begin
            fb = crc[31] ^ din;
            nhf_step = {crc[30:0], 1'b0} ^ (fb ? `NHF_CRC_POLY : 32'h0);
        end
    endfunction

    reg [31:0] crc_v;            // running residue
    integer    i;                // bit counter

    // low 32 bits then upper 16, all ones start
    always @* begin
        crc_v = `NHF_CRC_INIT;
        for (i = 0; i < `NHF_ADDR_W; i = i + 1) begin
            crc_v = nhf_step(crc_v, dest_addr[i]);
        end
    end

    // nine most significant residue bits, reversed: bit 23 is index msb
    assign hash_index = {crc_v[23], crc_v[24], crc_v[25], crc_v[26],
                         crc_v[27], crc_v[28], crc_v[29], crc_v[30],
                         crc_v[31]};

endmodule
`default_nettype wire

// ---- rtl/nhf_ctrl.v ----
// nhf_ctrl.v : hash destination filter, reset / self test and irq status
// assumes: one clock, setup buffer arrives as 32 longword strobes, frame
// destination arrives as one strobe before the frame is committed
`timescale 1ns/1ns
`default_nettype none
`include "nhf_consts.vh"

module nhf_ctrl #(
    parameter SELFTEST_CYC = `NHF_SELFTEST_CYC,
    parameter BLACKOUT_CYC = `NHF_BLACKOUT_CYC
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        arst_n,
    input  wire        clk_en,
    // software control
    input  wire        soft_reset_bit,
    input  wire        irq_enable_bit,
    input  wire        mode_wr,
    input  wire [3:0]  burst_limit_in,
    input  wire        selftest_fault,
    input  wire [3:0]  selftest_code,
    // host register access handshake
    input  wire        reg_req,
    output wire        reg_ack,
    // status access
    input  wire        status_wr,
    input  wire [11:0] status_wdata,
    output reg  [11:0] irq_status_reg,
    output reg  [3:0]  burst_limit_field,
    output reg  [15:0] rx_watchdog_count,
    output reg  [15:0] tx_watchdog_count,
    output reg         soft_reset_rd,
    output reg         procs_stopped,
    output wire        irq_req,
    // events
    input  wire        rx_done_evt,
    input  wire        tx_done_evt,
    input  wire        rx_unavail_evt,
    // setup frame load
    input  wire        setup_start,
    input  wire        hash_mode_select,
    input  wire        setup_wr,
    input  wire [31:0] setup_word,
    input  wire        setup_end,
    output reg         setup_error,
    output reg         hash_mode_reg,
    // frame destination check
    input  wire        dest_valid,
    input  wire [47:0] dest_addr,
    output reg         filt_valid,
    output reg         filt_accept
);

    // =================================================================
    // states
    // =================================================================
    localparam [3:0] ST_RESET = 4'b0001;   // reset sequence
    localparam [3:0] ST_TEST  = 4'b0010;   // self test running
    localparam [3:0] ST_READY = 4'b0100;   // taking host commands
    localparam [3:0] ST_FAIL  = 4'b1000;   // self test aborted

    reg [3:0]  state_reg;                  // control state
    reg [3:0]  state_next;                 // its next value
    reg [31:0] cnt_reg;                    // cycles since reset release
    reg [2:0]  rst_sync_reg;               // soft reset edge tracking
    reg        soft_rst_reg;               // soft reset in progress
    reg        soft_seen_reg;              // last reset came from software
    reg        irq_line_reg;               // interrupt request
    reg [`NHF_LWORD_W-1:0] table_mem [0:`NHF_LWORDS-1]; // hash buckets
    reg [47:0] station_reg;                // station physical address
    reg [5:0]  setup_idx_reg;              // longword count, 32 needs 6 bits
    reg        setup_busy_reg;             // setup buffer arriving
    wire [8:0] hash_index;                 // table index of destination
    wire [11:0] status_next;               // status after set and clear
    wire [11:0] evt_set;                   // newly raised status bits
    wire       soft_kick;                  // soft reset start request
    wire       blackout;                   // register accesses ignored
    genvar     g;

    // =================================================================
    // reset request
    // =================================================================
    // soft reset bit is same-clock logic; a mode write with it set starts the sequence unless one is in progress
    assign soft_kick = soft_reset_bit & mode_wr & ~soft_rst_reg;

    // =================================================================
    // state machine
    // =================================================================
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: state_next = ST_TEST;
            ST_TEST: begin
                // first failing test aborts the run
                if (selftest_fault) begin
                    state_next = ST_FAIL;
                end else if (cnt_reg >= SELFTEST_CYC - 1) begin
                    state_next = ST_READY;
                end
            end
            ST_READY: state_next = ST_READY;
            ST_FAIL:  state_next = ST_FAIL;
            default:  state_next = ST_RESET;
        endcase
    end

    // clocked control state; soft reset reruns the sequence
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg     <= ST_RESET;
            cnt_reg       <= 32'h0;
            soft_rst_reg  <= 1'b0;
            soft_seen_reg <= 1'b0;
            rst_sync_reg  <= 3'h0;
        end else if (clk_en) begin
            rst_sync_reg <= {rst_sync_reg[1:0], soft_reset_bit};
            if (soft_kick) begin
                state_reg     <= ST_RESET;
                cnt_reg       <= 32'h0;
                soft_rst_reg  <= 1'b1;
                soft_seen_reg <= 1'b1;
            end else begin
                state_reg <= state_next;
                if (cnt_reg != 32'hffffffff) begin
                    cnt_reg <= cnt_reg + 32'h1;
                end
                if (state_reg == ST_READY) begin
                    soft_rst_reg <= 1'b0;
                end
            end
        end
    end

    // =================================================================
    // host access blackout
    // =================================================================
    // no answer inside the first millisecond, so the bus times out
    assign blackout = (cnt_reg < BLACKOUT_CYC);
    // host keeps to status reads during test; device does not police it
    // beyond the blackout
    assign reg_ack  = reg_req & ~blackout;

    // =================================================================
    // configuration registers
    // =================================================================
    // non-zero reset values; soft reset reads back as one
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            burst_limit_field <= `NHF_BURST_RST;
            rx_watchdog_count <= `NHF_WDOG_RST;
            tx_watchdog_count <= `NHF_WDOG_RST;
            soft_reset_rd     <= 1'b0;
            procs_stopped     <= 1'b1;
        end else if (clk_en) begin
            if (soft_kick) begin
                burst_limit_field <= `NHF_BURST_RST;
                rx_watchdog_count <= `NHF_WDOG_RST;
                tx_watchdog_count <= `NHF_WDOG_RST;
                soft_reset_rd     <= 1'b1;
            end else if (mode_wr && reg_ack) begin
                burst_limit_field <= burst_limit_in;
            end
            // rx and tx come up stopped and stay stopped; nothing here starts them
            procs_stopped <= 1'b1;
        end
    end

    // =================================================================
    // interrupt status
    // =================================================================
    assign evt_set[`NHF_ST_RX_DONE]    = rx_done_evt & (state_reg == ST_READY);
    assign evt_set[`NHF_ST_TX_DONE]    = tx_done_evt & (state_reg == ST_READY);
    assign evt_set[`NHF_ST_RX_UNAVAIL] = rx_unavail_evt &
                                         (state_reg == ST_READY);
    assign evt_set[11:3] = 9'h0;

    // write one clears, but a same-cycle set wins
    assign status_next = (irq_status_reg &
                          ~(status_wr && reg_ack ? status_wdata : 12'h0))
                         | evt_set;

    // status update and done / fail flags
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status_reg <= 12'h020;             // done indicator reads one
        end else if (clk_en) begin
            if (soft_kick) begin
                irq_status_reg <= 12'h020;
            end else begin
                irq_status_reg <= status_next;
                irq_status_reg[`NHF_ST_RST_DONE] <= 1'b1;
                if (state_reg == ST_TEST && state_next == ST_READY) begin
                    irq_status_reg[`NHF_ST_INIT_DONE] <= 1'b1;
                end
                if (state_reg == ST_TEST && state_next == ST_FAIL) begin
                    irq_status_reg[`NHF_ST_FAIL] <= 1'b1;
                    irq_status_reg[11:8] <= selftest_code;
                end
            end
        end
    end

    // request rises only on a new event, drops once status bits 2:0 are all clear;
    // a recurring pending event does not re-raise it
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_line_reg <= 1'b0;
        end else if (clk_en) begin
            if (soft_kick) begin
                irq_line_reg <= 1'b0;
            end else if ((status_next & `NHF_ST_IRQ_MASK) == 12'h0) begin
                irq_line_reg <= 1'b0;
            end else if (|(evt_set & ~irq_status_reg)) begin
                irq_line_reg <= 1'b1;
            end
        end
    end

    // gated by the enable bit, sourced only from status
    assign irq_req = irq_line_reg & irq_enable_bit;

    // =================================================================
    // setup frame load
    // =================================================================
    // 32 longwords: 16 table words then station address
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            setup_idx_reg  <= 6'h0;
            setup_busy_reg <= 1'b0;
            setup_error    <= 1'b0;
            hash_mode_reg  <= 1'b0;
            station_reg    <= 48'h0;
        end else if (clk_en) begin
            if (soft_kick) begin
                setup_busy_reg <= 1'b0;
                hash_mode_reg  <= 1'b0;
                station_reg    <= 48'h0;
            end else if (setup_start) begin
                setup_idx_reg  <= 6'h0;
                setup_busy_reg <= 1'b1;
                setup_error    <= 1'b0;
                hash_mode_reg  <= hash_mode_select;
            end else if (setup_busy_reg && setup_wr) begin
                setup_idx_reg <= setup_idx_reg + 6'h1;
                if (setup_idx_reg == 6'h10) begin
                    station_reg[31:0] <= setup_word;
                end
                if (setup_idx_reg == 6'h11) begin
                    station_reg[47:32] <= setup_word[15:0];
                end
            end else if (setup_busy_reg && setup_end) begin
                setup_busy_reg <= 1'b0;
                // anything but exactly 128 bytes is an error
                setup_error <= (setup_idx_reg != 6'h20) | setup_wr;
            end
        end
    end

    // table longwords, zeroed by any reset
    generate
        for (g = 0; g < `NHF_LWORDS; g = g + 1) begin : gen_tbl
            always @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    table_mem[g] <= 32'h0;
                end else if (clk_en) begin
                    if (soft_kick) begin
                        table_mem[g] <= 32'h0;
                    end else if (setup_busy_reg && setup_wr &&
                                 setup_idx_reg == g) begin
                        table_mem[g] <= setup_word;
                    end
                end
            end
        end
    endgenerate

    // =================================================================
    // destination filter
    // =================================================================
    nhf_crc_hash u_hash (
        .dest_addr  (dest_addr),
        .hash_index (hash_index)
    );

    // one cycle after the destination, ahead of any commit
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            filt_valid  <= 1'b0;
            filt_accept <= 1'b0;
        end else if (clk_en) begin
            filt_valid <= dest_valid;
            if (dest_valid) begin
                if (!hash_mode_reg) begin
                    // perfect filtering lives elsewhere; accept here
                    filt_accept <= 1'b1;
                end else if (dest_addr[0]) begin
                    // multicast bit: hash lookup
                    filt_accept <= table_mem[hash_index[8:5]][hash_index[4:0]];
                    // longword index/32, bit index%32
                end else begin
                    filt_accept <= (dest_addr == station_reg);
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- tb/nhf_checker.sv ----
// nhf_checker.sv : concurrent checks on the nhf_ctrl ports
// assumes: bound to nhf_ctrl, clk_en held high by the bench
`timescale 1ns/1ns
`default_nettype none
module nhf_checker #(
    parameter SELFTEST_CYC = 40,
    parameter BLACKOUT_CYC = 10
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        arst_n,
    // host side
    input wire logic        soft_reset_bit,
    input wire logic        irq_enable_bit,
    input wire logic        mode_wr,
    input wire logic        reg_ack,
    input wire logic        status_wr,
    input wire logic [11:0] status_wdata,
    input wire logic        rx_done_evt,
    input wire logic [11:0] irq_status_reg,
    input wire logic [3:0]  burst_limit_field,
    input wire logic [15:0] rx_watchdog_count,
    input wire logic        soft_reset_rd,
    input wire logic        procs_stopped,
    input wire logic        irq_req,
    // filter side
    input wire logic        dest_valid,
    input wire logic        hash_mode_reg,
    input wire logic        filt_valid,
    input wire logic        filt_accept
);
    // ========
    // helper: cycles since last reset
    // ========
    localparam int LIM = SELFTEST_CYC + 4;
    int  cyc_reg;                         // saturates so the bound fires once
    wire soft_go = mode_wr && soft_reset_bit;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cyc_reg <= 0;
        end else if (soft_go) begin
            cyc_reg <= 0;                 // soft reset restarts both spans
        end else if (cyc_reg < LIM) begin
            cyc_reg <= cyc_reg + 1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ========
    // assertions
    // ========
    sequence s_probe_open;
        dest_valid && !hash_mode_reg;
    endsequence
    sequence s_answer_ok;
        filt_valid && filt_accept;
    endsequence
    a_filt_answer: assert property (filt_valid == $past(dest_valid))
        else $error("late answer");
    a_open_accept: assert property (s_probe_open |=> s_answer_ok)
        else $error("open reject");
    a_blackout_quiet: assert property ((cyc_reg < BLACKOUT_CYC) |-> !reg_ack)
        else $error("ack in blackout");
    a_selftest_bound: assert property ((cyc_reg == SELFTEST_CYC + 3)
        |-> (irq_status_reg[3] || irq_status_reg[4]))
        else $error("self test late");
    a_rst_values: assert property ($rose(arst_n) |-> irq_status_reg == 12'h020
        && burst_limit_field == 4'h1 && rx_watchdog_count == 16'h04e2)
        else $error("reset values");
    a_soft_restart: assert property (soft_go |=> soft_reset_rd
        && irq_status_reg == 12'h020)
        else $error("no soft restart");
    a_irq_gate: assert property (irq_req |-> irq_enable_bit
        && irq_status_reg[2:0] != 3'b000)
        else $error("stray irq");
    a_evt_sets: assert property (rx_done_evt && irq_status_reg[3] && !soft_go
        |=> irq_status_reg[0])
        else $error("no status set");
    a_w1c_clears: assert property (status_wr && reg_ack && status_wdata[0]
        && !rx_done_evt && !soft_go |=> !irq_status_reg[0])
        else $error("w1c failed");
    a_procs_stopped: assert property (procs_stopped)
        else $error("procs running");
endmodule
bind nhf_ctrl nhf_checker #(.SELFTEST_CYC(SELFTEST_CYC),
    .BLACKOUT_CYC(BLACKOUT_CYC)) i_nhf_checker (.sys_clk, .arst_n,
    .soft_reset_bit, .irq_enable_bit, .mode_wr, .reg_ack, .status_wr,
    .status_wdata, .rx_done_evt, .irq_status_reg, .burst_limit_field,
    .rx_watchdog_count, .soft_reset_rd, .procs_stopped, .irq_req,
    .dest_valid, .hash_mode_reg, .filt_valid, .filt_accept);
`default_nettype wire

// ---- tb/nhf_ctrl_tb.sv ----
// nhf_ctrl_tb.sv : self-checking bench for nhf_ctrl
// assumes: short self test and blackout parameters, clk_en tied high
`timescale 1ns/1ns
`default_nettype none
module nhf_ctrl_tb;
    localparam int ST = 40;               // short self test
    localparam int BO = 10;               // short blackout
    logic sys_clk = 0, arst_n = 0, soft_reset_bit = 0, irq_enable_bit = 0;
    logic mode_wr = 0, selftest_fault = 0, reg_req = 0, status_wr = 0;
    logic rx_done_evt = 0, tx_done_evt = 0, rx_unavail_evt = 0, send = 0;
    logic setup_start = 0, hash_mode_select = 0, setup_wr = 0, setup_end = 0;
    logic [3:0]  burst_limit_in = 0, selftest_code = 0, burst_limit_field, c;
    logic [11:0] status_wdata = 0, irq_status_reg;
    logic [15:0] rx_wd, tx_wd;
    logic [31:0] setup_word = 0, rng = 32'd70, words[32];
    logic [47:0] tb_addr = 0, dest_addr, station, a, mult[6];
    logic [511:0] tbl;
    logic reg_ack, soft_reset_rd, procs_stopped, irq_req, setup_error;
    logic hash_mode_reg, filt_valid, filt_accept, dest_valid;
    logic exp_q[$];                       // expected answers
    int err_total = 0, n_tests = 0;
    always #10 sys_clk = ~sys_clk;
    nhf_wire_src i_nhf_wire_src (.sys_clk, .send, .addr(tb_addr),
        .dest_valid, .dest_addr);
    nhf_ctrl #(.SELFTEST_CYC(ST), .BLACKOUT_CYC(BO)) i_nhf_ctrl (.sys_clk,
        .arst_n, .clk_en(1'b1), .soft_reset_bit, .irq_enable_bit, .mode_wr,
        .burst_limit_in, .selftest_fault, .selftest_code, .reg_req, .reg_ack,
        .status_wr, .status_wdata, .irq_status_reg, .burst_limit_field,
        .rx_watchdog_count(rx_wd), .tx_watchdog_count(tx_wd), .soft_reset_rd,
        .procs_stopped, .irq_req, .rx_done_evt, .tx_done_evt, .rx_unavail_evt,
        .setup_start, .hash_mode_select, .setup_wr, .setup_word, .setup_end,
        .setup_error, .hash_mode_reg, .dest_valid, .dest_addr, .filt_valid,
        .filt_accept);
    // ========
    // helpers: rng, reference hash, compare
    // ========
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic [8:0] hidx(input logic [47:0] d);
        logic [31:0] r;
        r = 32'hffffffff;
        for (int i = 0; i < 48; i++) begin
            r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? 32'h04c11db7 : 32'h0);
        end
        return {<<{r[31:23]}};            // bit 23 is index msb
    endfunction
    task automatic chk(input string what, input logic [47:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wait_ready(input logic [11:0] exp);
        for (int n = 0; n < ST + 5 && !irq_status_reg[4:3]; n++) begin
            tick(1);
        end
        #1;
        chk("selftest_end", irq_status_reg, exp);
    endtask
    task automatic evts(input logic [2:0] m);
        @(posedge sys_clk);
        {rx_unavail_evt, tx_done_evt, rx_done_evt} <= m;
        @(posedge sys_clk);
        {rx_unavail_evt, tx_done_evt, rx_done_evt} <= 3'b000;
        #1;
    endtask
    task automatic clr(input logic [11:0] m);
        @(posedge sys_clk);
        status_wr    <= 1'b1;
        status_wdata <= m;
        @(posedge sys_clk);
        status_wr    <= 1'b0;
        #1;
    endtask
    task automatic mode(input logic srst, input logic [3:0] bl);
        @(posedge sys_clk);
        mode_wr        <= 1'b1;
        soft_reset_bit <= srst;
        burst_limit_in <= bl;
        @(posedge sys_clk);
        mode_wr        <= 1'b0;
        soft_reset_bit <= 1'b0;
        #1;
    endtask
    task automatic setup(input logic hm, input int n);
        @(posedge sys_clk);
        setup_start      <= 1'b1;
        hash_mode_select <= hm;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            setup_start <= 1'b0;
            setup_wr    <= 1'b1;
            setup_word  <= words[i];
        end
        @(posedge sys_clk);
        setup_wr  <= 1'b0;
        setup_end <= 1'b1;
        @(posedge sys_clk);
        setup_end <= 1'b0;
        #1;
        chk("setup_error", setup_error, n != 32);
        chk("hash_mode", hash_mode_reg, hm);
    endtask
    task automatic frame(input logic [47:0] d, input logic exp);
        @(posedge sys_clk);
        send    <= 1'b1;
        tb_addr <= d;
        exp_q.push_back(exp);
        @(posedge sys_clk);
        send    <= 1'b0;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ========
    // monitor: answers matched to oldest note
    // ========
    always @(negedge sys_clk) begin
        if (filt_valid === 1'b1) begin
            chk("filt_accept", filt_accept, exp_q.pop_front());
        end
    end
    initial begin
        #400000;
        err_total++;
        summarize();
    end
    // ========
    // main sequence
    // ========
    initial begin
        tick(10);
        arst_n <= 1'b1;
        tick(1);
        #1;
        chk("rst_status", irq_status_reg, 12'h020);
        chk("rst_wdog", {rx_wd, tx_wd}, {2{16'h04e2}});
        chk("rst_burst", {procs_stopped, burst_limit_field}, 5'h11);
        @(posedge sys_clk);
        reg_req <= 1'b1;
        tick(2);
        #1;
        chk("blackout_ack", reg_ack, 1'b0);
        wait_ready(12'h028);
        chk("ack_after", reg_ack, 1'b1);
        $display("test reset done");
        @(posedge sys_clk);
        irq_enable_bit <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            evts(3'b001 << i);
            chk("irq_set", {irq_req, irq_status_reg[2:0]}, 4'h8 | (1 << i));
            evts(3'b001 << i);
            chk("irq_again", {irq_req, irq_status_reg[2:0]}, 4'h8 | (1 << i));
            clr(12'h001 << i);
            chk("irq_clr", {irq_req, irq_status_reg[2:0]}, 4'h0);
        end
        evts(3'b111);
        chk("irq_multi", {irq_req, irq_status_reg[2:0]}, 4'hf);
        clr(12'h003);
        chk("irq_part", {irq_req, irq_status_reg[2:0]}, 4'hc);
        clr(12'h004);
        chk("irq_gone", irq_req, 1'b0);
        @(posedge sys_clk);
        irq_enable_bit <= 1'b0;
        evts(3'b001);
        chk("irq_masked", {irq_req, irq_status_reg[2:0]}, 4'h1);
        clr(12'h001);
        c = rnd();
        mode(1'b0, c);
        chk("burst", burst_limit_field, c);
        $display("test irq done");
        tbl = '0;
        for (int k = 0; k < 6; k++) begin
            mult[k] = {rnd(), rnd()} | 48'h1;
            tbl[hidx(mult[k])] = 1'b1;
        end
        station = {rnd(), rnd()} & ~48'h1;
        for (int w = 0; w < 32; w++) begin
            words[w] = (w < 16) ? tbl[w * 32 +: 32] : 32'h0;
        end
        words[16] = station[31:0];
        words[17] = {16'h0, station[47:32]};
        setup(1'b1, 31);
        setup(1'b1, 32);
        for (int k = 0; k < 6; k++) begin
            frame(mult[k], 1'b1);
        end
        frame(station, 1'b1);
        frame(station ^ 48'h100, 1'b0);
        for (int k = 0; k < 16; k++) begin
            a = {rnd(), rnd()};
            frame(a, a[0] ? tbl[hidx(a)] : a == station);
        end
        tick(4);
        chk("queue_empty", exp_q.size(), 0);
        $display("test filter done");
        mode(1'b1, 4'h0);
        chk("soft_status", irq_status_reg, 12'h020);
        chk("soft_flags", {soft_reset_rd, hash_mode_reg}, 2'b10);
        wait_ready(12'h028);
        frame(48'h1, 1'b1);
        tick(4);
        c = rnd() | 32'h1;
        @(posedge sys_clk);
        selftest_fault <= 1'b1;
        selftest_code  <= c;
        arst_n         <= 1'b0;
        tick(10);
        arst_n         <= 1'b1;
        wait_ready({c, 8'h30});
        @(posedge sys_clk);
        selftest_fault <= 1'b0;
        $display("test soft reset and fault done");
        summarize();
    end
endmodule
`default_nettype wire

// ---- tb/nhf_wire_src.sv ----
// nhf_wire_src.sv : wire side, hands one destination per received frame
// assumes: bench raises send for one cycle per frame
`timescale 1ns/1ns
`default_nettype none
module nhf_wire_src (
    // clock
    input  wire logic        sys_clk,
    // request from the bench
    input  wire logic        send,
    input  wire logic [47:0] addr,
    // destination strobe toward the filter
    output var  logic        dest_valid,
    output var  logic [47:0] dest_addr
);
    // ========
    // one strobe a frame; stale address is scrambled, never held
    // ========
    always @(posedge sys_clk) begin
        if (send) begin
            dest_valid <= 1'b1;
            dest_addr  <= addr;          // first wire byte in [7:0]
        end else begin
            dest_valid <= 1'b0;
            dest_addr  <= ~dest_addr;    // catches a filter reading late
        end
    end
endmodule
`default_nettype wire
